// ---- core/clbi_pkg.sv ----
// package of the local bus interface: cycle kinds, status codes, timing counts
// assumes a single 100 MHz clock domain and no software-visible registers
package clbi_pkg;

    // ************************************************************
    // bus cycle kinds requested by the execution side
    // ************************************************************
    typedef enum logic [2:0] {
        CLBI_K_FETCH = 3'h0,
        CLBI_K_MRD   = 3'h1,
        CLBI_K_MWR   = 3'h2,
        CLBI_K_IORD  = 3'h3,
        CLBI_K_IOWR  = 3'h4,
        CLBI_K_INT_ACK_STROBE_N  = 3'h5,
        CLBI_K_HALT  = 3'h6
    } clbi_kind_type;

    // ************************************************************
    // bus states
    // ************************************************************
    typedef enum logic [2:0] {
        CLBI_S_IDLE = 3'h0,
        CLBI_S_T1   = 3'h1,
        CLBI_S_T2   = 3'h2,
        CLBI_S_T3   = 3'h3,
        CLBI_S_TW   = 3'h4,
        CLBI_S_T4   = 3'h5,
        CLBI_S_HOLD = 3'h6
    } clbi_state_type;

    // ************************************************************
    // coded cycle status (active low on the pins)
    // ************************************************************
    localparam logic [2:0] CLBI_ST_INT_ACK_STROBE_N  = 3'h0;
    localparam logic [2:0] CLBI_ST_IORD  = 3'h1;
    localparam logic [2:0] CLBI_ST_IOWR  = 3'h2;
    localparam logic [2:0] CLBI_ST_HALT  = 3'h3;
    localparam logic [2:0] CLBI_ST_FETCH = 3'h4;
    localparam logic [2:0] CLBI_ST_MRD   = 3'h5;
    localparam logic [2:0] CLBI_ST_MWR   = 3'h6;
    localparam logic [2:0] CLBI_ST_PASV  = 3'h7;

    // ************************************************************
    // field positions and timing
    // ************************************************************
    localparam int         CLBI_ADDR_W       = 20;
    localparam int         CLBI_IO_W         = 16;
    localparam logic [3:0] CLBI_IO_HIGH_ZERO = 4'h0;
    localparam int         CLBI_VEC_SHIFT    = 2;     // type byte times four
    localparam int         CLBI_RELEASE_NS   = 50;    // least low time of sync input
    localparam int         CLBI_CLK_NS       = 10;
    localparam logic [3:0] CLBI_RELEASE_CYC  =
        4'((CLBI_RELEASE_NS + CLBI_CLK_NS - 1) / CLBI_CLK_NS);
endpackage : clbi_pkg

// ---- core/clbi_sync.sv ----
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module clbi_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // level
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_q;

    // ************************************************************
    // first flop feeds only the second
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q    <= RST_VAL;
            level_out <= RST_VAL;
        end else if (clk_en) begin
            meta_q    <= pin_in;
            level_out <= meta_q;
        end
    end
endmodule : clbi_sync

// ---- core/clbi_bus_if.sv ----
// local bus interface: bus cycle sequencer, lock, request/grant, wait-on-sync
// assumes one clock; execution side is on the same clock, pins are async
// Functional notes
// - lock output goes low the cycle after the lock prefix is decoded.
// - lock releases at end of last bus cycle of the following instruction.
// - request/grant arriving under lock is recorded, granted after release.
// - wait with sync input high suspends, no bus cycles, until input low.
// - hold during wait floats every bus driver.
// - interrupt during wait refetches wait once, services, returns to wait.
// - strap high drives strobes; strap low drives coded cycle status.
// - read starts in T1 with address latch pulse; its fall marks address valid.
// - memory/io select holds the cycle's space from T1 through T4.
// - in T2 of read, address floats and read strobe asserts on the same edge.
// - write data driven from T2 until T4.
// - write strobe from start of T2 through T3, wait states and T4.
// - high byte enable and address bit zero select word, upper, lower, none.
// - even bytes on low data lines, odd bytes on high data lines.
// - acknowledge cycle uses read timing, acknowledge strobe, floated address.
// - second acknowledge returns type byte; pointer is byte times four.
// - maximum mode outputs three-bit cycle status for the controller.
// - minimum mode drives transceiver direction and enable itself.
// - status codes halt 011, fetch 100, read 101, write 110, passive 111.
// - lock held from T2 of first acknowledge to T2 of second.
// - io cycles zero top four address lines, port on low sixteen.
`timescale 1ns/1ps
module clbi_bus_if (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // pins in
    input  wire logic        min_max_strap,
    input  wire logic        ready_pin,
    input  wire logic        test_n_pin,
    input  wire logic        request_grant_line_i,
    input  wire logic        hold_pin,
    input  wire logic [15:0] ad_i,
    // execution side requests
    input  wire logic        req_valid,
    input  wire clbi_pkg::clbi_kind_type req_kind,
    input  wire logic [19:0] req_addr,
    input  wire logic        req_word,
    input  wire logic [15:0] req_wdata,
    input  wire logic        lock_prefix,
    input  wire logic        instr_end,
    input  wire logic        wait_instr,
    input  wire logic        int_pending,
    // execution side answers
    output logic             req_ready,
    output logic             done,
    output logic [15:0]      rdata,
    output logic [9:0]       vec_ptr,
    output logic             wait_suspended,
    output logic             wait_int_refetch,
    // bus pins out
    output logic [15:0]      ad_o,
    output logic             ad_oe,
    output logic [3:0]       a_hi_o,
    output logic             a_hi_oe,
    output logic             high_byte_enable_n,
    output logic             ale,
    output logic             mem_io_sel,
    output logic             rd_n,
    output logic             wr_n,
    output logic             int_ack_strobe_n,
    output logic             ctl_oe,
    output logic             xcvr_direction,
    output logic             xcvr_enable_n,
    output logic [2:0]       cycle_status,
    output logic             lock_n,
    output logic             request_grant_line_o,
    output logic             request_grant_line_oe,
    output logic             hold_ack
);

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        clbi_pkg::clbi_state_type st;
        clbi_pkg::clbi_kind_type  kind;
        logic [19:0] addr;
        logic        word;
        logic [15:0] wdata;
        logic        int_ack_strobe_n_second;
        logic        lock_pend;
        logic        lock_inst;
        logic        lock_int_ack_strobe_n;
        logic        rqgt_pend;
        logic        waiting;
        logic        refetch;
        logic        req_ready;
        logic        done;
        logic [15:0] rdata;
        logic [9:0]  vec_ptr;
        logic [15:0] ad_o;
        logic        ad_oe;
        logic [3:0]  a_hi_o;
        logic        a_hi_oe;
        logic        bhe_n;
        logic        ale;
        logic        mio;
        logic        rd_n;
        logic        wr_n;
        logic        int_ack_strobe_n_n;
        logic        ctl_oe;
        logic        dtr;
        logic        den_n;
        logic [2:0]  cst;
        logic        lock_n;
        logic        rg_o;
        logic        rg_oe;
        logic        hlda;
    } clbi_regs_type;

    clbi_regs_type r_q;
    clbi_regs_type r_d;
    logic          ready_s;
    logic          test_n_s;
    logic          rg_s;
    logic          hold_s;
    logic          strap_s;
    logic [3:0]    tst_low_cnt_q;

    // ************************************************************
    // pin synchronisers, generated for the five async levels
    // ************************************************************
    logic [4:0] pins_raw;
    logic [4:0] pins_s;
    assign pins_raw = {min_max_strap, ready_pin, test_n_pin, request_grant_line_i, hold_pin};
    generate
        for (genvar gi = 0; gi < 5; gi++) begin : g_sync
            // idle-high pins start high, so no false request or release follows reset
            clbi_sync #(.RST_VAL(gi >= 1 && gi <= 3)) u_sync (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .clk_en    (clk_en),
                .pin_in    (pins_raw[gi]),
                .level_out (pins_s[gi])
            );
        end
    endgenerate
    assign {strap_s, ready_s, test_n_s, rg_s, hold_s} = pins_s;

    // status code for a cycle kind
    function automatic logic [2:0] kind_status(input clbi_pkg::clbi_kind_type k);
        unique case (k)
            clbi_pkg::CLBI_K_FETCH: kind_status = clbi_pkg::CLBI_ST_FETCH;
            clbi_pkg::CLBI_K_MRD:   kind_status = clbi_pkg::CLBI_ST_MRD;
            clbi_pkg::CLBI_K_MWR:   kind_status = clbi_pkg::CLBI_ST_MWR;
            clbi_pkg::CLBI_K_IORD:  kind_status = clbi_pkg::CLBI_ST_IORD;
            clbi_pkg::CLBI_K_IOWR:  kind_status = clbi_pkg::CLBI_ST_IOWR;
            clbi_pkg::CLBI_K_INT_ACK_STROBE_N:  kind_status = clbi_pkg::CLBI_ST_INT_ACK_STROBE_N;
            clbi_pkg::CLBI_K_HALT:  kind_status = clbi_pkg::CLBI_ST_HALT;
            default:                kind_status = clbi_pkg::CLBI_ST_PASV;
        endcase
    endfunction : kind_status

    // write-direction kinds
    function automatic logic is_write(input clbi_pkg::clbi_kind_type k);
        is_write = (k == clbi_pkg::CLBI_K_MWR) || (k == clbi_pkg::CLBI_K_IOWR);
    endfunction : is_write

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        logic min_mode;
        logic wr_c;
        min_mode = strap_s;
        wr_c     = is_write(r_q.kind);
        r_d           = r_q;
        r_d.done      = 1'b0;
        r_d.ale       = 1'b0;
        r_d.req_ready = 1'b0;
        // lock prefix: pin falls the cycle after decode
        if (lock_prefix) begin
            r_d.lock_inst = 1'b1;
            r_d.lock_pend = 1'b1;
        end
        if (r_q.lock_pend && instr_end && r_q.st == clbi_pkg::CLBI_S_IDLE && !lock_prefix) begin
            r_d.lock_inst = 1'b0;
            r_d.lock_pend = 1'b0;
        end
        // request under lock is remembered
        // the other master's release pulse in hold must not count as a new request
        if (!rg_s && r_q.st != clbi_pkg::CLBI_S_HOLD) begin
            r_d.rqgt_pend = 1'b1;
        end
        // wait on sync input
        if (wait_instr && test_n_s) begin
            r_d.waiting = 1'b1;
        end
        if (r_q.waiting && !test_n_s && tst_low_cnt_q >= clbi_pkg::CLBI_RELEASE_CYC - 4'h1) begin
            r_d.waiting = 1'b0;
        end
        if (r_q.waiting && int_pending) begin
            r_d.waiting = 1'b0;
            r_d.refetch = 1'b1;
        end
        if (r_q.refetch && r_q.done && r_q.kind == clbi_pkg::CLBI_K_FETCH) begin
            r_d.refetch = 1'b0;
        end
        unique case (r_q.st)
            clbi_pkg::CLBI_S_IDLE: begin
                r_d.rd_n = 1'b1;
                r_d.wr_n = 1'b1;
                r_d.int_ack_strobe_n_n = 1'b1;
                r_d.den_n = 1'b1;
                r_d.ad_oe = 1'b0;
                r_d.a_hi_oe = 1'b0;
                r_d.cst = clbi_pkg::CLBI_ST_PASV;
                if (hold_s && !r_d.lock_inst && !r_q.lock_int_ack_strobe_n) begin
                    r_d.st = clbi_pkg::CLBI_S_HOLD;
                    r_d.ctl_oe = 1'b0;
                    r_d.hlda = 1'b1;
                end else if (r_q.rqgt_pend && !r_d.lock_inst && !r_q.lock_int_ack_strobe_n) begin
                    r_d.rg_o = 1'b0;
                    r_d.rg_oe = 1'b1;
                    r_d.rqgt_pend = 1'b0;
                    r_d.st = clbi_pkg::CLBI_S_HOLD;
                    r_d.ctl_oe = 1'b0;
                end else if (req_valid && !r_q.waiting) begin
                    r_d.req_ready = 1'b1;
                    r_d.kind = req_kind;
                    r_d.word = req_word;
                    r_d.wdata = req_wdata;
                    r_d.st = clbi_pkg::CLBI_S_T1;
                    r_d.ctl_oe = 1'b1;
                    r_d.ale = min_mode;
                    r_d.cst = kind_status(req_kind);
                    r_d.mio = !((req_kind == clbi_pkg::CLBI_K_IORD) || (req_kind == clbi_pkg::CLBI_K_IOWR));
                    r_d.dtr = !is_write(req_kind);
                    r_d.bhe_n = !(req_word || req_addr[0]);
                    r_d.addr = req_addr;
                    if ((req_kind == clbi_pkg::CLBI_K_IORD) || (req_kind == clbi_pkg::CLBI_K_IOWR)) begin
                        r_d.a_hi_o = clbi_pkg::CLBI_IO_HIGH_ZERO;
                    end else begin
                        r_d.a_hi_o = req_addr[19:16];
                    end
                    r_d.ad_o = req_addr[15:0];
                    r_d.a_hi_oe = (req_kind != clbi_pkg::CLBI_K_INT_ACK_STROBE_N);
                    r_d.ad_oe = (req_kind != clbi_pkg::CLBI_K_INT_ACK_STROBE_N);
                end
            end
            clbi_pkg::CLBI_S_T1: begin
                r_d.st = clbi_pkg::CLBI_S_T2;
                if (r_q.kind == clbi_pkg::CLBI_K_HALT) begin
                    r_d.st = clbi_pkg::CLBI_S_T4;
                    r_d.ad_oe = 1'b0;
                end else if (wr_c) begin
                    r_d.wr_n = !min_mode;
                    r_d.ad_o = r_q.word ? r_q.wdata :
                        (r_q.addr[0] ? {r_q.wdata[7:0], 8'h00} : {8'h00, r_q.wdata[7:0]});
                    r_d.ad_oe = 1'b1;
                    r_d.den_n = !min_mode;
                end else begin
                    r_d.ad_oe = 1'b0;
                    r_d.rd_n = !(min_mode && r_q.kind != clbi_pkg::CLBI_K_INT_ACK_STROBE_N);
                    r_d.int_ack_strobe_n_n = !(min_mode && r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N);
                    r_d.den_n = !min_mode;
                end
                if (r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N && !r_q.int_ack_strobe_n_second) begin
                    r_d.lock_int_ack_strobe_n = 1'b1;
                end else if (r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N) begin
                    r_d.lock_int_ack_strobe_n = 1'b0;
                end
            end
            clbi_pkg::CLBI_S_T2: begin
                r_d.st = clbi_pkg::CLBI_S_T3;
                r_d.cst = clbi_pkg::CLBI_ST_PASV;
            end
            clbi_pkg::CLBI_S_T3, clbi_pkg::CLBI_S_TW: begin
                if (ready_s) begin
                    r_d.st = clbi_pkg::CLBI_S_T4;
                    if (!wr_c) begin
                        r_d.rdata = ad_i;
                    end
                    // only the second acknowledge carries the type byte
                    if (r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N && r_q.int_ack_strobe_n_second) begin
                        r_d.vec_ptr = {ad_i[7:0], 2'h0};
                    end
                end else begin
                    r_d.st = clbi_pkg::CLBI_S_TW;
                end
            end
            clbi_pkg::CLBI_S_T4: begin
                r_d.st = clbi_pkg::CLBI_S_IDLE;
                r_d.rd_n = 1'b1;
                r_d.wr_n = 1'b1;
                r_d.int_ack_strobe_n_n = 1'b1;
                r_d.den_n = 1'b1;
                r_d.ad_oe = 1'b0;
                r_d.done = 1'b1;
                if (r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N) begin
                    r_d.int_ack_strobe_n_second = !r_q.int_ack_strobe_n_second;
                end
            end
            clbi_pkg::CLBI_S_HOLD: begin
                r_d.ad_oe = 1'b0;
                r_d.a_hi_oe = 1'b0;
                r_d.ctl_oe = 1'b0;
                if (!hold_s && r_q.hlda) begin
                    r_d.hlda = 1'b0;
                    r_d.st = clbi_pkg::CLBI_S_IDLE;
                end else if (!r_q.hlda && !rg_s && r_q.rg_oe == 1'b0) begin
                    r_d.st = clbi_pkg::CLBI_S_IDLE;            // release pulse from the other master
                end
                r_d.rg_oe = 1'b0;
                r_d.rg_o = 1'b1;
            end
            default: r_d.st = clbi_pkg::CLBI_S_IDLE;
        endcase
        r_d.lock_n = !(r_d.lock_inst || r_d.lock_int_ack_strobe_n);
    end

    // ************************************************************
    // registers; sync low-time counter kept beside the record
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q <= '{st: clbi_pkg::CLBI_S_IDLE, kind: clbi_pkg::CLBI_K_FETCH, cst: clbi_pkg::CLBI_ST_PASV,
                     rd_n: 1'b1, wr_n: 1'b1, int_ack_strobe_n_n: 1'b1, den_n: 1'b1, bhe_n: 1'b1, lock_n: 1'b1,
                     rg_o: 1'b1, mio: 1'b1, dtr: 1'b1, default: '0};
            tst_low_cnt_q <= 4'h0;
        end else if (clk_en) begin
            r_q <= r_d;
            if (test_n_s) begin
                tst_low_cnt_q <= 4'h0;
            end else if (tst_low_cnt_q != 4'hF) begin
                tst_low_cnt_q <= tst_low_cnt_q + 4'h1;
            end
        end
    end

    // ************************************************************
    // outputs straight from the record
    // ************************************************************
    assign req_ready             = r_q.req_ready;
    assign done                  = r_q.done;
    assign rdata                 = r_q.rdata;
    assign vec_ptr               = r_q.vec_ptr;
    assign wait_suspended        = r_q.waiting;
    assign wait_int_refetch      = r_q.refetch;
    assign ad_o                  = r_q.ad_o;
    assign ad_oe                 = r_q.ad_oe;
    assign a_hi_o                = r_q.a_hi_o;
    assign a_hi_oe               = r_q.a_hi_oe;
    assign high_byte_enable_n    = r_q.bhe_n;
    assign ale                   = r_q.ale;
    assign mem_io_sel            = r_q.mio;
    assign rd_n                  = r_q.rd_n;
    assign wr_n                  = r_q.wr_n;
    assign int_ack_strobe_n      = r_q.int_ack_strobe_n_n;
    assign ctl_oe                = r_q.ctl_oe;
    assign xcvr_direction        = r_q.dtr;
    assign xcvr_enable_n         = r_q.den_n;
    assign cycle_status          = r_q.cst;
    assign lock_n                = r_q.lock_n;
    assign request_grant_line_o  = r_q.rg_o;
    assign request_grant_line_oe = r_q.rg_oe;
    assign hold_ack              = r_q.hlda;

    // ************************************************************
    // checks
    // ************************************************************
    a_lock_follow: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && lock_prefix |=> !lock_n) else $error("lock not asserted after prefix");
    a_no_grant_lock: assert property (@(posedge clk) disable iff (sys_rst)
        !lock_n |-> !request_grant_line_oe) else $error("grant issued under lock");
    a_wait_no_bus: assert property (@(posedge clk) disable iff (sys_rst)
        wait_suspended && $past(wait_suspended) |-> !ale) else $error("bus cycle while waiting");
    a_hold_float: assert property (@(posedge clk) disable iff (sys_rst)
        hold_ack |-> !ad_oe && !ctl_oe) else $error("drivers on during hold");
    a_halt_code: assert property (@(posedge clk) disable iff (sys_rst)
        r_q.st == clbi_pkg::CLBI_S_T1 && r_q.kind == clbi_pkg::CLBI_K_HALT |-> cycle_status == 3'h3)
        else $error("halt status wrong");
    a_read_float: assert property (@(posedge clk) disable iff (sys_rst)
        !rd_n |-> !ad_oe) else $error("read with address driven");
    a_write_data: assert property (@(posedge clk) disable iff (sys_rst)
        !wr_n |-> ad_oe) else $error("write strobe without data");
    a_int_ack_strobe_n_float: assert property (@(posedge clk) disable iff (sys_rst)
        !int_ack_strobe_n |-> !ad_oe) else $error("bus driven in acknowledge");
    a_vec_times4: assert property (@(posedge clk) disable iff (sys_rst)
        done && r_q.kind == clbi_pkg::CLBI_K_INT_ACK_STROBE_N && !r_q.int_ack_strobe_n_second |-> vec_ptr == {rdata[7:0], 2'h0})
        else $error("vector not times four");
endmodule : clbi_bus_if

// ---- bench/clbi_mem_model.sv ----
// partner model: memory, io port and interrupt logic answering on the local bus
// assumes active low strobes; n_wait sets how many clocks ready stays low
`timescale 1ns/1ps
module clbi_mem_model (
    // clock and strobes
    input  wire logic        clk,
    input  wire logic        rd_n,
    input  wire logic        int_ack_strobe_n,
    input  wire logic        wr_n,
    input  wire logic [3:0]  n_wait,
    // answer
    output logic [15:0]      ad_i,
    output logic             ready_pin
);
    localparam logic [15:0] WORD = 16'h3C23;  // low byte doubles as the type byte
    logic [3:0] cnt_q = 4'h0;
    initial ad_i = 16'h0000;
    // released bus inverts every clock, so stale data matches the answer only on every other clock
    always @(posedge clk) begin
        ad_i <= (!rd_n || !int_ack_strobe_n) ? WORD : ~ad_i;
        cnt_q <= (rd_n && int_ack_strobe_n && wr_n) ? 4'h0 : cnt_q + 4'h1;
    end
    assign ready_pin = (cnt_q >= n_wait);
endmodule : clbi_mem_model

// ---- bench/tb_clbi_bus_if.sv ----
// testbench of the local bus interface: scenario tasks against a memory model
// assumes request held until req_ready pulses, done pulse after T4
`timescale 1ns/1ps
module tb_clbi_bus_if;
    logic clk = 1'b0, sys_rst = 1'b1, strap = 1'b1, test_n = 1'b1, req_valid = 1'b0, req_word = 1'b0;
    logic lock_prefix = 1'b0, instr_end = 1'b0, wait_instr = 1'b0, req_ready, done, ale, mio, wr_n, rd_n;
    logic int_ack_strobe_n_n, lock_n, bhe_n, wait_susp, ready, bhe_s, mio_s;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000, ad_i, ad_o, rdata, lo_s, wd_s;
    logic [9:0]  vec_ptr;
    logic [3:0]  a_hi, a_hi_s, n_wait = 4'h0;
    logic [2:0]  cst, cs_s;
    clbi_pkg::clbi_kind_type req_kind = clbi_pkg::CLBI_K_MRD;
    int n_fail = 0, total_checks = 0, cyc_n = 0;

    always #5 clk = ~clk;

    clbi_mem_model clbi_mem_model_i (.clk(clk), .rd_n(rd_n), .int_ack_strobe_n(int_ack_strobe_n_n), .wr_n(wr_n),
        .n_wait(n_wait), .ad_i(ad_i), .ready_pin(ready));
    clbi_bus_if clbi_bus_if_i (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .min_max_strap(strap),
        .ready_pin(ready), .test_n_pin(test_n), .request_grant_line_i(1'b1), .hold_pin(1'b0), .ad_i(ad_i),
        .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_word(req_word),
        .req_wdata(req_wdata), .lock_prefix(lock_prefix), .instr_end(instr_end), .wait_instr(wait_instr),
        .int_pending(1'b0), .req_ready(req_ready), .done(done), .rdata(rdata), .vec_ptr(vec_ptr),
        .wait_suspended(wait_susp), .wait_int_refetch(), .ad_o(ad_o), .ad_oe(), .a_hi_o(a_hi), .a_hi_oe(),
        .high_byte_enable_n(bhe_n), .ale(ale), .mem_io_sel(mio), .rd_n(rd_n), .wr_n(wr_n),
        .int_ack_strobe_n(int_ack_strobe_n_n), .ctl_oe(), .xcvr_direction(), .xcvr_enable_n(), .cycle_status(cst),
        .lock_n(lock_n), .request_grant_line_o(), .request_grant_line_oe(), .hold_ack());

    // bus monitor: latch what the pins show in each phase, plus the hang limit
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (ale) {bhe_s, a_hi_s, lo_s, mio_s} <= {bhe_n, a_hi, ad_o, mio};
        if (!wr_n) wd_s <= ad_o;
        if (cst != 3'h7) cs_s <= cst;
        if (cyc_n == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // bounded wait for a registered pulse; a miss counts as a mismatch
    task automatic wait_for(ref logic s, input string nm);
        int i = 0;
        @(posedge clk);
        while (s !== 1'b1 && i < 60) begin
            @(posedge clk);
            i++;
        end
        chk(nm, 20'h1, {19'h0, s});
    endtask : wait_for

    task automatic cyc(input clbi_pkg::clbi_kind_type k, input logic [19:0] a, input logic w, input logic [15:0] d);
        req_kind <= k;
        req_addr <= a;
        req_word <= w;
        req_wdata <= d;
        req_valid <= 1'b1;
        wait_for(req_ready, "req_ready");
        req_valid <= 1'b0;
        wait_for(done, "done");
    endtask : cyc

    // lanes, latch strobe, space select, read data with prompt and slow ready
    task automatic t_read();
        for (int i = 0; i < 4; i++) begin
            n_wait <= 4'(3 * (i / 3));
            cyc(clbi_pkg::CLBI_K_MRD, 20'h52344 + 20'(i % 2), 1'(i % 3 == 0), 16'h0000);
            chk("bhe_n", {19'h0, !(i % 3 == 0 || i % 2 == 1)}, {19'h0, bhe_s});
            chk("addr", 20'h52344 + 20'(i % 2), {a_hi_s, lo_s});
            chk("mio", 20'h1, {19'h0, mio_s});
            if (i % 3 == 0) chk("rdata", 20'h03C23, {4'h0, rdata});
        end
        // strobe-less max mode cycles need a ready that does not wait on a strobe
        n_wait <= 4'h0;
    endtask : t_read

    task automatic t_write_io();
        cyc(clbi_pkg::CLBI_K_MWR, 20'h00010, 1'b1, 16'hBEEF);
        chk("wdata", 20'h0BEEF, {4'h0, wd_s});
        cyc(clbi_pkg::CLBI_K_IORD, 20'hF1234, 1'b1, 16'h0000);
        chk("io_addr", 20'h01234, {a_hi_s, lo_s});
        chk("io_mio", 20'h0, {19'h0, mio_s});
        cyc(clbi_pkg::CLBI_K_INT_ACK_STROBE_N, 20'h00000, 1'b0, 16'h0000);
        chk("vec_first", 20'h0, {10'h0, vec_ptr});
        cyc(clbi_pkg::CLBI_K_INT_ACK_STROBE_N, 20'h00000, 1'b0, 16'h0000);
        chk("vec_ptr", 20'h0008C, {10'h0, vec_ptr});
    endtask : t_write_io

    // coded status in maximum mode for fetch, read, write and halt
    task automatic t_max();
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            cyc(clbi_pkg::clbi_kind_type'(i), 20'h00100, 1'b1, 16'h1111);
            chk("status", 20'h4 + 20'(i), {17'h0, cs_s});
        end
        cyc(clbi_pkg::CLBI_K_HALT, 20'h00100, 1'b1, 16'h0000);
        chk("halt", 20'h3, {17'h0, cs_s});
        strap <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : t_max

    task automatic t_lock_wait();
        lock_prefix <= 1'b1;
        @(posedge clk);
        lock_prefix <= 1'b0;
        repeat (2) @(posedge clk);
        chk("lock_on", 20'h0, {19'h0, lock_n});
        cyc(clbi_pkg::CLBI_K_MRD, 20'h00200, 1'b1, 16'h0000);
        instr_end <= 1'b1;
        @(posedge clk);
        instr_end <= 1'b0;
        repeat (3) @(posedge clk);
        chk("lock_off", 20'h1, {19'h0, lock_n});
        wait_instr <= 1'b1;
        repeat (6) @(posedge clk);
        chk("suspended", 20'h1, {19'h0, wait_susp});
        test_n <= 1'b0;
        repeat (10) @(posedge clk);
        wait_instr <= 1'b0;
        chk("resumed", 20'h0, {19'h0, wait_susp});
    endtask : t_lock_wait

    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_read();
        t_write_io();
        t_max();
        t_lock_wait();
        finish_test();
    end
endmodule : tb_clbi_bus_if
